// ### design/sis_defs.svh
// Constants for the software interrupt sequencer: flag positions,
// stack step, vector segment word offset and fixed interrupt types.
// Assumes the flags word uses the push-flags instruction layout.
//
// Functional notes
// - Entry lowers the stack pointer by 2, then stores the flags word.
// - After the flags save, the step and enable flags are cleared to 0.
// - The saved flags word has the push-flags instruction layout.
// - Then the stack pointer drops by 2 and the code segment is stored.
// - Vector entry is type times 4; its word at plus 2 loads the segment.
// - A third push 2 lower saves the pointer; vector word 0 reloads it.
// - A one-byte breakpoint form behaves as interrupt type 3.
// - Overflow trap enters only if the overflow flag is 1; else no effect.
// - Overflow trap uses type 4, vector at 10H, code segment at 12H.
// - A taken overflow trap clears both flags and follows the same steps.
// - Return pops pointer, code segment, flags, adding 2 after each.
// - Return replaces every flag with the popped word, for any handler.
// - Jump-if-above tests carry/zero, OR form by default, AND on request.
// - A taken short jump adds the 8-bit displacement, sign-extended.
`ifndef SIS_DEFS_SVH
`define SIS_DEFS_SVH
`define SIS_BIT_CARRY 0
`define SIS_BIT_ZERO 6
`define SIS_BIT_STEP 8
`define SIS_BIT_ENABLE 9
`define SIS_BIT_OVERFLOW 11
`define SIS_STACK_STEP 16'h0002
`define SIS_VEC_HI_OFS 20'h00002
`define SIS_BRK_TYPE 8'h03
`define SIS_OVF_TYPE 8'h04
`define SIS_WORD_RST 16'h0000
`endif

// ### design/sis_pkg.sv
// Types shared by the sequencer and its helpers.
// Assumes sis_defs.svh is on the include path.
package sis_pkg;
`include "sis_defs.svh"

  typedef enum logic [2:0] {
    SIS_OP_SWINT,
    SIS_OP_BREAK,
    SIS_OP_OVF_TRAP,
    SIS_OP_TRAP_RET,
    SIS_OP_JUMP_ABOVE
  } sis_op_t;

  typedef struct packed {
    sis_op_t op;
    logic [7:0] itype;
    logic [7:0] short_displacement;
  } sis_cmd_t;

  typedef struct packed {
    logic [15:0] flags;
    logic [15:0] cs;
    logic [15:0] instruction_pointer;
    logic [15:0] stack_pointer;
  } sis_ctx_t;

  typedef enum logic [3:0] {
    S_IDLE, S_PUSH_FL, S_PUSH_CS, S_RD_CS, S_PUSH_PTR, S_RD_PTR,
    S_POP_PTR, S_POP_CS, S_POP_FL, S_DONE
  } sis_state_t;

  typedef enum logic [1:0] {W_IDLE, W_LO, W_HI} sis_wstate_t;

  // Segment and offset to a 20-bit physical address
  function automatic logic [19:0] sis_phys(input logic [15:0] seg,
                                           input logic [15:0] ofs);
    sis_phys = {seg, 4'h0} + {4'h0, ofs};
  endfunction

  // Vector entry address: type times four
  function automatic logic [19:0] sis_vec(input logic [7:0] t);
    sis_vec = {10'h000, t, 2'b00};
  endfunction
endpackage

// ### design/sis_word_port.sv
// Splits one 16-bit stack or vector access overflow_trap_instr two byte accesses.
// Assumes a byte memory on the same clock answering with mem_ack_i.
`timescale 1ns/1ps
`include "sis_defs.svh"
module sis_word_port
  import sis_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Word request
  input wire logic start_i,
  input wire logic we_i,
  input wire logic [19:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic done_o,
  output logic [15:0] rdata_o,
  // Byte memory
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [19:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [7:0] mem_rdata_i
);
  sis_wstate_t state, next_state;
  logic we, next_we, done, next_done;
  logic [19:0] addr, next_addr;
  logic [15:0] wdata, next_wdata, rdata, next_rdata;

  // Low byte at the address, high byte one above
  always_comb
  begin
    next_state = state;
    next_we = we;
    next_addr = addr;
    next_wdata = wdata;
    next_rdata = rdata;
    next_done = 1'b0;
    case (state)
      W_IDLE:
        if (start_i)
        begin
          next_state = W_LO;
          next_we = we_i;
          next_addr = addr_i;
          next_wdata = wdata_i;
        end
      W_LO:
        if (mem_ack_i)
        begin
          next_state = W_HI;
          next_addr = addr + 20'h00001;
          next_rdata = {8'h00, mem_rdata_i};
        end
      W_HI:
        if (mem_ack_i)
        begin
          next_state = W_IDLE;
          next_done = 1'b1;
          next_rdata = {mem_rdata_i, rdata[7:0]};
        end
      default: next_state = W_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= W_IDLE;
      we <= 1'b0;
      addr <= 20'h00000;
      wdata <= `SIS_WORD_RST;
      rdata <= `SIS_WORD_RST;
      done <= 1'b0;
    end
    else
    begin
      state <= next_state;
      we <= next_we;
      addr <= next_addr;
      wdata <= next_wdata;
      rdata <= next_rdata;
      done <= next_done;
    end
  end

  assign done_o = done;
  assign rdata_o = rdata;
  assign mem_req_o = (state != W_IDLE);
  assign mem_we_o = we;
  assign mem_addr_o = addr;
  assign mem_wdata_o = (state == W_HI) ? wdata[15:8] : wdata[7:0];

  a_high_byte_next: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == W_LO && mem_ack_i) |=>
      mem_addr_o == $past(mem_addr_o) + 20'h00001 &&
      mem_wdata_o == wdata[15:8])
    else $error("high byte not at next address");
endmodule

// ### design/sis_branch.sv
// Condition and target for the short jump-if-above instruction.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`include "sis_defs.svh"
module sis_branch
  import sis_pkg::*;
(
  // Operands
  input wire logic [15:0] flags_i,
  input wire logic [15:0] instruction_pointer_i,
  input wire logic [7:0] short_displacement_i,
  input wire logic and_form_i,
  // Result
  output logic take_o,
  output logic [15:0] target_o
);
  function automatic logic [15:0] sext8(input logic [7:0] d);
    sext8 = {{8{d[7]}}, d};
  endfunction

  logic carry_clear, zero_clear;

  // OR form by default; the AND form is the usual unsigned "above"
  always_comb
  begin
    carry_clear = !flags_i[`SIS_BIT_CARRY];
    zero_clear = !flags_i[`SIS_BIT_ZERO];
    take_o = and_form_i ? (carry_clear && zero_clear)
                        : (carry_clear || zero_clear);
    target_o = instruction_pointer_i + sext8(short_displacement_i);
  end
endmodule

// ### design/sis_sequencer.sv
// Execution sequencing for software interrupt entry, interrupt return
// and the short jump-if-above. Holds a working copy of flags, code
// segment, pointer and stack pointer while an instruction runs.
// Assumes the core supplies the context with each command and that a
// byte-wide memory on the same clock holds stack and vector table.
`timescale 1ns/1ps
`include "sis_defs.svh"
module sis_sequencer
  import sis_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Command from decode
  input wire logic cmd_valid_i,
  input wire sis_cmd_t cmd_i,
  output logic cmd_ready_o,
  // Context in and out
  input wire sis_ctx_t ctx_i,
  input wire logic [15:0] stack_seg_i,
  input wire logic above_and_form_i,
  output sis_ctx_t ctx_o,
  output logic taken_o,
  output logic done_o,
  // Byte memory
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [19:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [7:0] mem_rdata_i
);
  sis_state_t state, next_state;
  sis_ctx_t ctx, next_ctx;
  sis_op_t op, next_op;
  logic [15:0] ss, next_ss;
  logic [19:0] vec, next_vec;
  logic pend, next_pend, taken, next_taken;
  logic wp_start, wp_we, wp_done, mem_step, push_step;
  logic [19:0] wp_addr;
  logic [15:0] wp_wdata, wp_rdata;
  logic br_take;
  logic [15:0] br_target;

  sis_word_port u_word (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(wp_start),
    .we_i(wp_we),
    .addr_i(wp_addr),
    .wdata_i(wp_wdata),
    .done_o(wp_done),
    .rdata_o(wp_rdata),
    .mem_req_o(mem_req_o),
    .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o),
    .mem_ack_i(mem_ack_i),
    .mem_rdata_i(mem_rdata_i)
  );

  // Evaluated on the incoming context so the jump needs no memory
  sis_branch u_branch (
    .flags_i(ctx_i.flags),
    .instruction_pointer_i(ctx_i.instruction_pointer),
    .short_displacement_i(cmd_i.short_displacement),
    .and_form_i(above_and_form_i),
    .take_o(br_take),
    .target_o(br_target)
  );

  // Access set up per state; pushes address the lowered pointer
  always_comb
  begin
    mem_step = 1'b1;
    push_step = 1'b0;
    wp_we = 1'b0;
    wp_addr = 20'h00000;
    wp_wdata = `SIS_WORD_RST;
    case (state)
      S_PUSH_FL:
      begin
        push_step = 1'b1;
        wp_we = 1'b1;
        wp_addr = sis_phys(ss, ctx.stack_pointer - `SIS_STACK_STEP);
        wp_wdata = ctx.flags;
      end
      S_PUSH_CS:
      begin
        push_step = 1'b1;
        wp_we = 1'b1;
        wp_addr = sis_phys(ss, ctx.stack_pointer - `SIS_STACK_STEP);
        wp_wdata = ctx.cs;
      end
      S_PUSH_PTR:
      begin
        push_step = 1'b1;
        wp_we = 1'b1;
        wp_addr = sis_phys(ss, ctx.stack_pointer - `SIS_STACK_STEP);
        wp_wdata = ctx.instruction_pointer;
      end
      S_RD_CS: wp_addr = vec + `SIS_VEC_HI_OFS;
      S_RD_PTR: wp_addr = vec;
      S_POP_PTR, S_POP_CS, S_POP_FL:
        wp_addr = sis_phys(ss, ctx.stack_pointer);
      default: mem_step = 1'b0;
    endcase
    // One word access per memory state
    wp_start = mem_step && !pend;
  end

  // Sequence and context updates
  always_comb
  begin
    next_state = state;
    next_ctx = ctx;
    next_op = op;
    next_ss = ss;
    next_vec = vec;
    next_taken = taken;
    next_pend = pend;
    if (wp_start)
      next_pend = 1'b1;
    if (wp_done)
      next_pend = 1'b0;
    // Stack pointer drops as each push is issued
    if (wp_start && push_step)
      next_ctx.stack_pointer = ctx.stack_pointer - `SIS_STACK_STEP;
    case (state)
      S_IDLE:
        if (cmd_valid_i)
        begin
          next_ctx = ctx_i;
          next_ss = stack_seg_i;
          next_op = cmd_i.op;
          next_taken = 1'b1;
          next_vec = sis_vec(cmd_i.itype);
          next_state = S_PUSH_FL;
          case (cmd_i.op)
            SIS_OP_BREAK: next_vec = sis_vec(`SIS_BRK_TYPE);
            SIS_OP_OVF_TRAP:
            begin
              next_vec = sis_vec(`SIS_OVF_TYPE);
              if (!ctx_i.flags[`SIS_BIT_OVERFLOW])
              begin
                next_taken = 1'b0;
                next_state = S_DONE;
              end
            end
            SIS_OP_TRAP_RET: next_state = S_POP_PTR;
            SIS_OP_JUMP_ABOVE:
            begin
              next_taken = br_take;
              if (br_take)
                next_ctx.instruction_pointer = br_target;
              next_state = S_DONE;
            end
            default: next_state = S_PUSH_FL;
          endcase
        end
      S_PUSH_FL:
        if (wp_done)
        begin
          next_ctx.flags[`SIS_BIT_STEP] = 1'b0;
          next_ctx.flags[`SIS_BIT_ENABLE] = 1'b0;
          next_state = S_PUSH_CS;
        end
      S_PUSH_CS:
        if (wp_done)
          next_state = S_RD_CS;
      S_RD_CS:
        if (wp_done)
        begin
          next_ctx.cs = wp_rdata;
          next_state = S_PUSH_PTR;
        end
      S_PUSH_PTR:
        if (wp_done)
          next_state = S_RD_PTR;
      S_RD_PTR:
        if (wp_done)
        begin
          next_ctx.instruction_pointer = wp_rdata;
          next_state = S_DONE;
        end
      S_POP_PTR:
        if (wp_done)
        begin
          next_ctx.instruction_pointer = wp_rdata;
          next_ctx.stack_pointer = ctx.stack_pointer + `SIS_STACK_STEP;
          next_state = S_POP_CS;
        end
      S_POP_CS:
        if (wp_done)
        begin
          next_ctx.cs = wp_rdata;
          next_ctx.stack_pointer = ctx.stack_pointer + `SIS_STACK_STEP;
          next_state = S_POP_FL;
        end
      S_POP_FL:
        if (wp_done)
        begin
          next_ctx.flags = wp_rdata;
          next_ctx.stack_pointer = ctx.stack_pointer + `SIS_STACK_STEP;
          next_state = S_DONE;
        end
      S_DONE: next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= S_IDLE;
      ctx <= '0;
      op <= SIS_OP_SWINT;
      ss <= `SIS_WORD_RST;
      vec <= 20'h00000;
      pend <= 1'b0;
      taken <= 1'b0;
    end
    else
    begin
      state <= next_state;
      ctx <= next_ctx;
      op <= next_op;
      ss <= next_ss;
      vec <= next_vec;
      pend <= next_pend;
      taken <= next_taken;
    end
  end

  // Ready only between instructions; result valid in the done cycle
  assign cmd_ready_o = (state == S_IDLE);
  assign done_o = (state == S_DONE);
  assign ctx_o = ctx;
  assign taken_o = taken;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_fl_pushed;
    state == S_PUSH_FL && wp_done;
  endsequence

  sequence s_cs_popped;
    state == S_POP_CS && wp_done;
  endsequence

  a_flags_push_first: assert property (
    (state == S_PUSH_FL && wp_start) |->
      wp_we && wp_wdata == ctx.flags &&
      wp_addr == sis_phys(ss, ctx.stack_pointer - `SIS_STACK_STEP)
      ##1 ctx.stack_pointer == $past(ctx.stack_pointer) - `SIS_STACK_STEP)
    else $error("flags push address or pointer wrong");

  a_entry_flags_clear: assert property (
    s_fl_pushed |=> state == S_PUSH_CS &&
      !ctx.flags[`SIS_BIT_STEP] && !ctx.flags[`SIS_BIT_ENABLE])
    else $error("step or enable flag not cleared");

  a_cs_push_next: assert property (
    (state == S_PUSH_CS && wp_start) |->
      wp_wdata == ctx.cs &&
      wp_addr == sis_phys(ss, ctx.stack_pointer - `SIS_STACK_STEP))
    else $error("code segment push wrong");

  a_vector_cs_addr: assert property (
    (state == S_RD_CS && wp_start) |->
      !wp_we && wp_addr == vec + `SIS_VEC_HI_OFS)
    else $error("code segment vector address wrong");

  a_vector_ptr_load: assert property (
    (state == S_RD_PTR && wp_done) |=>
      ctx.instruction_pointer == $past(wp_rdata) && state == S_DONE)
    else $error("pointer not loaded from vector");

  a_break_type: assert property (
    (state == S_IDLE && cmd_valid_i && cmd_i.op == SIS_OP_BREAK) |=>
      vec == 20'h0000c && state == S_PUSH_FL)
    else $error("breakpoint not type 3");

  a_trap_skip: assert property (
    (state == S_IDLE && cmd_valid_i && cmd_i.op == SIS_OP_OVF_TRAP &&
     !ctx_i.flags[`SIS_BIT_OVERFLOW]) |=>
      state == S_DONE && !taken ##1 state == S_IDLE && !mem_req_o)
    else $error("overflow trap taken without overflow");

  a_trap_vectors: assert property (
    (op == SIS_OP_OVF_TRAP && wp_start &&
     (state == S_RD_CS || state == S_RD_PTR)) |->
      wp_addr == ((state == S_RD_CS) ? 20'h00012 : 20'h00010))
    else $error("overflow trap vector address wrong");

  a_return_order: assert property (
    s_cs_popped |=> state == S_POP_FL &&
      ctx.stack_pointer == $past(ctx.stack_pointer) + `SIS_STACK_STEP &&
      ctx.cs == $past(wp_rdata))
    else $error("return pop order or step wrong");

  a_jump_target: assert property (
    (state == S_IDLE && cmd_valid_i && cmd_i.op == SIS_OP_JUMP_ABOVE &&
     br_take) |=>
      ctx.instruction_pointer == $past(ctx_i.instruction_pointer) +
        {{8{$past(cmd_i.short_displacement[7])}},
         $past(cmd_i.short_displacement)})
    else $error("jump target wrong");
endmodule

// ### sim/sis_mem_model.sv
// Byte memory partner of the sequencer: stack and vector table.
// Assumes the sequencer's clock; answers each byte after delay_i waits.
`timescale 1ns/1ps
module sis_mem_model
(
  // Clock
  input wire logic clk_i,
  // Byte requests from the sequencer
  input wire logic mem_req_i,
  input wire logic mem_we_i,
  input wire logic [19:0] mem_addr_i,
  input wire logic [7:0] mem_wdata_i,
  output logic mem_ack_o,
  output logic [7:0] mem_rdata_o,
  // Wait states before each answer
  input wire logic [3:0] delay_i
);
  logic [7:0] mem [logic [19:0]];
  logic [3:0] wait_cnt = 4'h0;

  initial
  begin
    mem_ack_o = 1'b0;
    mem_rdata_o = 8'h00;
  end

  // One-cycle ack; read data turns to its inverse once the ack is over
  always @(posedge clk_i)
  begin
    if (mem_ack_o)
    begin
      if (mem_we_i)
        mem[mem_addr_i] = mem_wdata_i;
      mem_ack_o <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
      wait_cnt <= 4'h0;
    end
    else if (mem_req_i && wait_cnt >= delay_i)
    begin
      mem_ack_o <= 1'b1;
      mem_rdata_o <= mem.exists(mem_addr_i) ? mem[mem_addr_i] : 8'h5a;
    end
    else if (mem_req_i)
      wait_cnt <= wait_cnt + 4'h1;
  end
endmodule

// ### sim/sis_sequencer_tb.sv
// Self-checking bench for the sequencer with a byte memory partner.
// Assumes the stack at segment 0200, offset 0100, vectors at segment 0.
`timescale 1ns/1ps
module sis_sequencer_tb
  import sis_pkg::*;
;
  logic clk_i, rst_i, cmd_valid_i, above_and_form_i;
  sis_cmd_t cmd_i;
  sis_ctx_t ctx_i, ctx_o;
  logic [15:0] stack_seg_i;
  logic cmd_ready_o, taken_o, done_o, mem_req_o, mem_we_o, mem_ack_i;
  logic [19:0] mem_addr_o;
  logic [7:0] mem_wdata_o, mem_rdata_i;
  logic [3:0] delay;
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;

  sis_sequencer sis_sequencer_i (.clk_i(clk_i), .rst_i(rst_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o),
    .ctx_i(ctx_i), .stack_seg_i(stack_seg_i),
    .above_and_form_i(above_and_form_i), .ctx_o(ctx_o), .taken_o(taken_o),
    .done_o(done_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i));

  sis_mem_model sis_mem_model_i (.clk_i(clk_i), .mem_req_i(mem_req_o),
    .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o),
    .mem_wdata_i(mem_wdata_o), .mem_ack_o(mem_ack_i),
    .mem_rdata_o(mem_rdata_i), .delay_i(delay));

  // 200 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Hang guard: far above the few hundred cycles the tests need
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Low byte at the address, high byte above it
  task automatic put_word(input logic [19:0] a, input logic [15:0] w);
    sis_mem_model_i.mem[a] = w[7:0];
    sis_mem_model_i.mem[a + 20'h1] = w[15:8];
  endtask

  function automatic logic [15:0] word_at(input logic [19:0] a);
    return {sis_mem_model_i.mem[a + 20'h1], sis_mem_model_i.mem[a]};
  endfunction

  // One command: present at a falling edge, wait for the done pulse
  task automatic run(input sis_op_t op, input logic [7:0] t, d,
    input logic [63:0] ctx, input logic af);
    int k;
    @(negedge clk_i);
    cmd_i = '{op, t, d};
    ctx_i = ctx;
    stack_seg_i = 16'h0200;
    above_and_form_i = af;
    cmd_valid_i = 1'b1;
    @(posedge clk_i);
    @(negedge clk_i);
    cmd_valid_i = 1'b0;
    // Looked at mid-cycle, where the one-cycle done pulse stands settled
    for (k = 0; k < 400; k++)
    begin
      if (done_o === 1'b1)
        break;
      @(negedge clk_i);
    end
    if (k == 400)
      check("done pulse", 64'h0, 64'h1);
  endtask

  // Interrupt entry through vector vt; stack top 0x02100
  task automatic entry(input sis_op_t op, input logic [7:0] t, vt);
    logic [19:0] va;
    va = {10'h000, vt, 2'b00};
    put_word(va, 16'hbe00 + 16'(vt));
    put_word(va + 20'h2, 16'hca00 + 16'(vt));
    run(op, t, 8'h00, {16'h0bd5, 16'h1234, 16'h5678, 16'h0100}, 1'b0);
    check("taken", 64'(taken_o), 64'h1);
    check("saved flags", 64'(word_at(20'h020fe)), 64'h0bd5);
    check("flags out", 64'(ctx_o.flags), 64'h08d5);
    check("saved cs", 64'(word_at(20'h020fc)), 64'h1234);
    check("saved ip", 64'(word_at(20'h020fa)), 64'h5678);
    check("cs out", 64'(ctx_o.cs), 64'hca00 + 64'(vt));
    check("ip out", 64'(ctx_o.instruction_pointer),
      64'hbe00 + 64'(vt));
    check("sp out", 64'(ctx_o.stack_pointer), 64'h00fa);
    $display("test entry %0h done", vt);
  endtask

  initial
  begin : main
    logic c, z, a, tk;
    logic [7:0] d;
    logic [15:0] exp_ptr;
    rst_i = 1'b1;
    cmd_valid_i = 1'b0;
    cmd_i = '0;
    ctx_i = '0;
    stack_seg_i = 16'h0000;
    above_and_form_i = 1'b0;
    delay = 4'h0;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    check("ready after reset", 64'(cmd_ready_o), 64'h1);
    check("ctx after reset", ctx_o, 64'h0);
    $display("test reset done");
    // Explicit type, breakpoint form, then the trap on slow memory
    entry(SIS_OP_SWINT, 8'h21, 8'h21);
    entry(SIS_OP_BREAK, 8'h55, 8'h03);
    delay = 4'h3;
    entry(SIS_OP_OVF_TRAP, 8'h77, 8'h04);
    // Return pops the frame left by the trap
    run(SIS_OP_TRAP_RET, 8'h00, 8'h00, {48'h0, 16'h00fa}, 1'b0);
    check("return ctx", ctx_o,
      {16'h0bd5, 16'h1234, 16'h5678, 16'h0100});
    check("return taken", 64'(taken_o), 64'h1);
    $display("test return done");
    // Trap with overflow clear must leave everything alone
    delay = 4'h0;
    run(SIS_OP_OVF_TRAP, 8'h00, 8'h00,
      {16'h0355, 16'h1234, 16'h5678, 16'h0100}, 1'b0);
    check("untaken trap", 64'(taken_o), 64'h0);
    check("untaken ctx", ctx_o,
      {16'h0355, 16'h1234, 16'h5678, 16'h0100});
    $display("test untaken trap done");
    // Reset in mid-entry: the byte access stops and the context clears
    @(negedge clk_i);
    cmd_i = '{SIS_OP_SWINT, 8'h21, 8'h00};
    ctx_i = {16'h0bd5, 16'h1234, 16'h5678, 16'h0100};
    cmd_valid_i = 1'b1;
    @(negedge clk_i);
    cmd_valid_i = 1'b0;
    repeat (3) @(negedge clk_i);
    check("busy mid-entry", 64'(mem_req_o), 64'h1);
    rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    check("req after mid reset", 64'(mem_req_o), 64'h0);
    check("ready after mid reset", 64'(cmd_ready_o), 64'h1);
    check("taken after mid reset", 64'(taken_o), 64'h0);
    check("ctx after mid reset", ctx_o, 64'h0);
    $display("test mid-run reset done");
    // Every carry/zero pair under both condition forms
    for (int i = 0; i < 8; i++)
    begin
      c = i[0];
      z = i[1];
      a = i[2];
      d = i[0] ? 8'h80 : 8'h7f;
      tk = a ? (!c && !z) : (!c || !z);
      exp_ptr = tk ? 16'h1000 + {{8{d[7]}}, d} : 16'h1000;
      run(SIS_OP_JUMP_ABOVE, 8'h00, d,
        {9'h000, z, 5'h00, c, 16'h1234, 16'h1000, 16'h0100}, a);
      check("jump taken", 64'(taken_o), 64'(tk));
      check("jump ptr", 64'(ctx_o.instruction_pointer),
        64'(exp_ptr));
    end
    $display("test jump done");
    conclude();
  end
endmodule
